/* hw/ntfcs_consts.svh */
// Offsets, field positions, reset values and thresholds of the target/FIFO/collision status bank.
// Assumes inclusion by bare name from the status bank module ntfcs_status.
`ifndef NTFCS_CONSTS_SVH
`define NTFCS_CONSTS_SVH

// Register indexes; byte address is four times the index
`define NTFCS_IDX_PT_FLAGS   6'h1d
`define NTFCS_IDX_FIFO_LO    6'h1e
`define NTFCS_IDX_FIFO_HI    6'h1f
`define NTFCS_IDX_COLLISION  6'h20
`define NTFCS_IDX_PT_MASK    6'h30

// Event flag bit positions
`define NTFCS_B_WAIT_TIMER   7
`define NTFCS_B_SLOT_LEVEL   6
`define NTFCS_B_FIELD_ON     5
`define NTFCS_B_AUTO_RX_END  4
`define NTFCS_B_HIGH_RATE    3
`define NTFCS_B_RESERVED     2
`define NTFCS_B_STAR_ACTIVE  1
`define NTFCS_B_ACTIVE       0

// Reset values
`define NTFCS_MASK_RST       8'h00
`define NTFCS_ZERO8          8'h00
`define NTFCS_ZERO32         32'h0000_0000

// Thresholds and codes
`define NTFCS_FIFO_DEPTH     10'h200
`define NTFCS_WL_RX_ABOVE    10'h12c
`define NTFCS_WL_TX_BELOW    10'h0c8
`define NTFCS_SLOTS_LEFT     8'h04
`define NTFCS_RATE_212       2'h1
`define NTFCS_RATE_424       2'h2

`endif

/* hw/ntfcs_pkg.sv */
// Types shared by the status bank and its sticky flag cell.
// Assumes ntfcs_consts.svh is on the include path.
package ntfcs_pkg;

    // Target state machine codes as reported by the target core
    typedef enum logic [3:0] {
        NTFCS_PTA_POWER_OFF = 4'h0,
        NTFCS_PTA_IDLE      = 4'h1,
        NTFCS_PTA_READY_1   = 4'h2,
        NTFCS_PTA_READY_2   = 4'h3,
        NTFCS_PTA_ACTIVE    = 4'h5,
        NTFCS_PTA_HALT      = 4'h9,
        NTFCS_PTA_READY_1S  = 4'ha,
        NTFCS_PTA_READY_2S  = 4'hb,
        NTFCS_PTA_ACTIVE_S  = 4'hd
    } ntfcs_pta_state_t;

    typedef struct packed {
        logic flag;
    } ntfcs_sticky_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  rd_clr;
        logic [9:0]  fifo_count;
        logic        fifo_unf;
        logic        fifo_ovr;
        logic [2:0]  lb_bits;
        logic        lb_np;
        logic [3:0]  col_byte;
        logic [2:0]  col_bit;
        logic        col_pb;
        logic        col_seen;
        logic        hard_err;
        logic [7:0]  mask;
        logic        irq;
        logic        water_level;
        logic [3:0]  prev_pta;
        logic [7:0]  prev_slots;
    } ntfcs_state_t;

endpackage

/* hw/ntfcs_status.sv */
// Status bank: target event flags, FIFO status, collision position, over APB.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "ntfcs_consts.svh"
module ntfcs_status
(
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        field_wait_timer_evt,
    input  wire logic [7:0]                  time_slot_number_unused,
    input  wire logic                        ca_done,
    input  wire logic                        ca_collision,
    input  wire logic                        field_on,
    input  wire logic                        passive_target_mode,
    input  wire logic                        auto_anticoll_reply_sent,
    input  wire logic                        auto_sensf_reply_sent,
    input  wire logic [1:0]                  rx_rate,
    input  wire ntfcs_pkg::ntfcs_pta_state_t target_state,
    input  wire logic                        fifo_push,
    input  wire logic                        fifo_pop,
    input  wire logic                        fifo_clear,
    input  wire logic                        rx_active,
    input  wire logic                        tx_active,
    input  wire logic                        rx_start,
    input  wire logic                        rx_end,
    input  wire logic [2:0]                  rx_last_bits,
    input  wire logic                        rx_parity_missing,
    input  wire logic                        framing_error_corrupt,
    input  wire logic                        collision_evt,
    input  wire logic                        anticoll_cmd,
    input  wire logic [3:0]                  collision_byte_in,
    input  wire logic [2:0]                  collision_bit_in,
    input  wire logic                        collision_parity_in,
    output logic                             pt_irq,
    output logic                             fifo_water_level,
    output logic                             hard_framing_error_flag
);
    import ntfcs_pkg::*;

    parameter int FIFO_DEPTH = 512;

    ntfcs_state_t st;
    ntfcs_state_t next_st;
    logic [7:0]   evt_set;
    logic [7:0]   evt_clr;
    logic [7:0]   evt_flags;
    logic [5:0]   idx;
    logic         setup;
    logic         done;
    logic         fifo_full;
    logic         fifo_empty;
    logic         do_push;
    logic         do_pop;
    logic         rate_high;

    assign idx        = paddr[7:2];
    assign setup      = psel && penable && !st.pready;
    assign done       = psel && penable && st.pready;
    assign fifo_full  = (st.fifo_count == FIFO_DEPTH[9:0]);
    assign fifo_empty = (st.fifo_count == 10'h000);
    assign do_push    = fifo_push && !fifo_full;
    assign do_pop     = fifo_pop && !fifo_empty;

    // Only the two higher rates arm bit 3; any other rate code never does
    always_comb
    begin
        case (rx_rate)
            `NTFCS_RATE_212:
            begin
                rate_high = 1'b1;
            end
            `NTFCS_RATE_424:
            begin
                rate_high = 1'b1;
            end
            default:
            begin
                rate_high = 1'b0;
            end
        endcase
    end

    // Event sources of the target flag register
    always_comb
    begin
        evt_set = `NTFCS_ZERO8;
        evt_set[`NTFCS_B_WAIT_TIMER]  = field_wait_timer_evt;
        evt_set[`NTFCS_B_SLOT_LEVEL]  = (time_slot_number_unused == `NTFCS_SLOTS_LEFT)
                                     && (st.prev_slots != `NTFCS_SLOTS_LEFT);
        evt_set[`NTFCS_B_FIELD_ON]    = ca_done && !ca_collision && field_on;
        evt_set[`NTFCS_B_AUTO_RX_END] = passive_target_mode
                                     && (auto_anticoll_reply_sent
                                     || auto_sensf_reply_sent);
        evt_set[`NTFCS_B_HIGH_RATE]   = auto_sensf_reply_sent && rate_high;
        evt_set[`NTFCS_B_STAR_ACTIVE] = (target_state == NTFCS_PTA_ACTIVE_S)
                                     && (st.prev_pta != NTFCS_PTA_ACTIVE_S);
        evt_set[`NTFCS_B_ACTIVE]      = (target_state == NTFCS_PTA_ACTIVE)
                                     && (st.prev_pta != NTFCS_PTA_ACTIVE);
    end

    // Only the bits handed out in the read data are cleared, so an event
    // arriving between capture and completion is kept for the next read
    always_comb
    begin
        evt_clr = `NTFCS_ZERO8;
        if (done && !pwrite && (idx == `NTFCS_IDX_PT_FLAGS))
        begin
            evt_clr = st.rd_clr;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_flag
            if (gi == `NTFCS_B_RESERVED)
            begin : g_rsvd
                assign evt_flags[gi] = 1'b0;
            end
            else
            begin : g_bit
                ntfcs_sticky u_flag
                (
                    .ref_clk (ref_clk),
                    .rst     (rst),
                    .set     (evt_set[gi]),
                    .clr     (evt_clr[gi]),
                    .q       (evt_flags[gi])
                );
            end
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        next_st.prev_pta   = target_state;
        next_st.prev_slots = time_slot_number_unused;

        // APB: one wait state, data and error captured with pready
        if (setup)
        begin
            next_st.pready  = 1'b1;
            next_st.pslverr = 1'b0;
            next_st.prdata  = `NTFCS_ZERO32;
            next_st.rd_clr  = `NTFCS_ZERO8;
            case (idx)
                `NTFCS_IDX_PT_FLAGS:
                begin
                    next_st.prdata[7:0] = evt_flags;
                    next_st.rd_clr      = evt_flags;
                end
                `NTFCS_IDX_FIFO_LO:
                begin
                    next_st.prdata[7:0] = st.fifo_count[7:0];
                end
                `NTFCS_IDX_FIFO_HI:
                begin
                    next_st.prdata[7:0] = {st.fifo_count[9:8], st.fifo_unf, st.fifo_ovr,
                                           st.lb_bits, st.lb_np};
                end
                `NTFCS_IDX_COLLISION:
                begin
                    next_st.prdata[7:0] = {st.col_byte, st.col_bit, st.col_pb};
                end
                `NTFCS_IDX_PT_MASK:
                begin
                    next_st.prdata[7:0] = st.mask;
                end
                default:
                begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        else if (done)
        begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.rd_clr  = `NTFCS_ZERO8;
        end
        else
        begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end

        // Status registers are read-only, so only the mask takes a write
        if (done && pwrite && idx == `NTFCS_IDX_PT_MASK)
        begin
            next_st.mask = pwdata[7:0];
        end

        // FIFO occupancy; a push and pop together leave it unchanged, except when empty (push counts) or full (pop counts)
        if (fifo_clear)
        begin
            next_st.fifo_count = 10'h000;
        end
        else if (do_push && !do_pop)
        begin
            next_st.fifo_count = st.fifo_count + 10'h001;
        end
        else if (do_pop && !do_push)
        begin
            next_st.fifo_count = st.fifo_count - 10'h001;
        end
        // Both error flags stick until a FIFO clear; a fresh error in the clear cycle wins
        if (fifo_clear)
        begin
            next_st.fifo_unf = 1'b0;
            next_st.fifo_ovr = 1'b0;
        end
        if (fifo_pop && fifo_empty)
        begin
            next_st.fifo_unf = 1'b1;
        end
        if (fifo_push && fifo_full && !fifo_pop)
        begin
            next_st.fifo_ovr = 1'b1;
        end

        // Last byte description, taken at end of reception
        if (rx_end)
        begin
            next_st.lb_bits = rx_last_bits;
            next_st.lb_np   = rx_parity_missing && (rx_last_bits == 3'h0);
        end

        // Hard framing error lives for one reception; a new error beats the clear
        if (rx_start)
        begin
            next_st.hard_err = 1'b0;
        end
        if (framing_error_corrupt)
        begin
            next_st.hard_err = 1'b1;
        end

        // First collision of an anticollision frame only
        if (rx_start)
        begin
            next_st.col_seen = 1'b0;
        end
        if (collision_evt && anticoll_cmd && (!st.col_seen || rx_start))
        begin
            next_st.col_seen = 1'b1;
            next_st.col_byte = collision_byte_in;
            next_st.col_bit  = collision_bit_in;
            next_st.col_pb   = collision_parity_in;
        end

        next_st.irq         = |(evt_flags & ~st.mask);
        next_st.water_level = (rx_active && st.fifo_count > `NTFCS_WL_RX_ABOVE)
                           || (tx_active && st.fifo_count < `NTFCS_WL_TX_BELOW);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st      <= '0;
            st.mask <= `NTFCS_MASK_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata                  = st.prdata;
    assign pready                  = st.pready;
    assign pslverr                 = st.pslverr;
    assign pt_irq                  = st.irq;
    assign fifo_water_level        = st.water_level;
    assign hard_framing_error_flag = st.hard_err;
endmodule // ntfcs_status

/* hw/ntfcs_sticky.sv */
// One event flag: set by hardware, cleared by a read of its register.
// Assumes set and clr are synchronous one-cycle pulses on ref_clk.
`timescale 1ns/10ps
module ntfcs_sticky
    import ntfcs_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    ntfcs_sticky_t st;
    ntfcs_sticky_t next_st;

    // Set beats clear so an event in the read cycle survives to the next read
    always_comb
    begin
        next_st = st;
        if (clr)
        begin
            next_st.flag = 1'b0;
        end
        if (set)
        begin
            next_st.flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q = st.flag;
endmodule // ntfcs_sticky

/* verif/ntfcs_host_model.sv */
// Host microcontroller model: APB master that reads and writes the bank.
// Assumes the slave answers with a one-cycle pready pulse.
`timescale 1ns/10ps
module ntfcs_host_model
(
    input  wire logic        ref_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request held until pready is sampled, so a read-clear happens exactly once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // ntfcs_host_model

/* verif/ntfcs_status_properties.sv */
// Checker for the status bank, bound to ntfcs_status.
// Assumes one clock domain and a well-formed APB master.
`timescale 1ns/10ps
module ntfcs_checker
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_start,
    input wire logic        framing_error_corrupt,
    input wire logic        hard_framing_error_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer)
        else $error("no answer after access cycle");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready held two cycles");
    property p_in_access; pready |-> psel && penable; endproperty
    a_in_access: assert property (p_in_access)
        else $error("ready outside an access");
    property p_unmapped;
        pready && !(paddr[7:2] inside {6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h30})
            |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_ro_write; pready && pwrite && paddr[7:2] inside {[6'h1d:6'h20]} |-> !pslverr;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("status write flagged as error");
    property p_reserved;
        pready && !pwrite && paddr == 8'h74 |-> prdata[31:8] == 24'h000000 && prdata[2] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved flag bit or upper lanes set");
    property p_err_set; framing_error_corrupt |=> hard_framing_error_flag; endproperty
    a_err_set: assert property (p_err_set)
        else $error("hard framing error not flagged");
    property p_err_clr;
        rx_start && !framing_error_corrupt |=> !hard_framing_error_flag;
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("hard framing error survived new frame");
endmodule // ntfcs_checker

bind ntfcs_status ntfcs_checker u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_start(rx_start), .framing_error_corrupt(framing_error_corrupt),
    .hard_framing_error_flag(hard_framing_error_flag));

/* verif/test_nfc_target_fifo_collision_status.sv */
// Testbench for the status bank: events, FIFO status and collision capture.
// Assumes the host model as APB master and the bound checker.
`timescale 1ns/10ps
module test_nfc_target_fifo_collision_status;
    import ntfcs_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, pt_irq, fifo_water_level;
    logic [7:0] paddr, time_slot_number_unused;
    logic [31:0] pwdata, prdata;
    logic field_wait_timer_evt, ca_done, ca_collision, field_on, passive_target_mode;
    logic auto_anticoll_reply_sent, auto_sensf_reply_sent, fifo_push, fifo_pop, fifo_clear;
    logic rx_active, tx_active, rx_start, rx_end, rx_parity_missing, framing_error_corrupt;
    logic collision_evt, anticoll_cmd, collision_parity_in, hard_framing_error_flag;
    logic [1:0] rx_rate;
    logic [2:0] rx_last_bits, collision_bit_in;
    logic [3:0] collision_byte_in;
    ntfcs_pta_state_t target_state;
    int fails = 0, tests_run = 0, cycles = 0;
    logic [7:0] flag_exp [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h18, 8'h02, 8'h01, 8'h00, 8'h08};

    ntfcs_status #(.FIFO_DEPTH(512)) dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .field_wait_timer_evt, .time_slot_number_unused,
        .ca_done, .ca_collision, .field_on, .passive_target_mode, .auto_anticoll_reply_sent,
        .auto_sensf_reply_sent, .rx_rate, .target_state, .fifo_push, .fifo_pop, .fifo_clear,
        .rx_active, .tx_active, .rx_start, .rx_end, .rx_last_bits, .rx_parity_missing,
        .framing_error_corrupt, .collision_evt, .anticoll_cmd, .collision_byte_in,
        .collision_bit_in, .collision_parity_in, .pt_irq, .fifo_water_level,
        .hard_framing_error_flag);
    ntfcs_host_model host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Whole run needs well under this; a hang lands in the report
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            finish_test();
        end
    end

    task check(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task rd(logic [7:0] a, logic [7:0] exp, logic err = 1'b0);
        logic [31:0] q;
        logic e;
        host.xfer(1'b0, a, 32'h0, q, e);
        check("read data", q, {24'h0, exp});
        check("slave error", {31'h0, e}, {31'h0, err});
    endtask

    task wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, a, {24'h0, d}, q, e);
        check("write error", {31'h0, e}, 32'h0);
    endtask

    task ev(int k);
        @(posedge ref_clk);
        case (k)
            0: field_wait_timer_evt <= 1'b1;
            1: time_slot_number_unused <= 8'h04;
            2: ca_done <= 1'b1;
            3: auto_anticoll_reply_sent <= 1'b1;
            4: auto_sensf_reply_sent <= 1'b1;
            5: target_state <= NTFCS_PTA_ACTIVE_S;
            6: target_state <= NTFCS_PTA_ACTIVE;
            7: {ca_done, ca_collision} <= 2'b11;
            default: {auto_sensf_reply_sent, passive_target_mode, rx_rate} <= 4'b1010;
        endcase
        @(posedge ref_clk);
        {field_wait_timer_evt, ca_done, ca_collision, auto_anticoll_reply_sent} <= 4'h0;
        {auto_sensf_reply_sent, passive_target_mode, rx_rate} <= 4'b0101;
        time_slot_number_unused <= 8'h05;
        target_state <= NTFCS_PTA_IDLE;
    endtask

    task col(logic ac, logic [3:0] by, logic [2:0] bi, logic pb);
        @(posedge ref_clk);
        {anticoll_cmd, collision_byte_in, collision_bit_in, collision_parity_in} <= {ac, by, bi, pb};
        collision_evt <= 1'b1;
        @(posedge ref_clk);
        collision_evt <= 1'b0;
    endtask

    task t_regs;
        rd(8'h74, 8'h00);
        rd(8'h78, 8'h00);
        rd(8'h7c, 8'h00);
        rd(8'h80, 8'h00);
        rd(8'hc0, 8'h00);
        rd(8'h40, 8'h00, 1'b1);
    endtask

    task t_flags;
        for (int k = 0; k < 9; k++)
        begin
            ev(k);
            rd(8'h74, flag_exp[k]);
            rd(8'h74, 8'h00);
        end
        ev(0);
        wr(8'h74, 8'hff);
        repeat (2) @(posedge ref_clk);
        check("interrupt", {31'h0, pt_irq}, 32'h1);
        rd(8'h74, 8'h80);
        repeat (2) @(posedge ref_clk);
        check("interrupt", {31'h0, pt_irq}, 32'h0);
        wr(8'hc0, 8'h80);
        rd(8'hc0, 8'h80);
        ev(0);
        repeat (2) @(posedge ref_clk);
        check("interrupt", {31'h0, pt_irq}, 32'h0);
        rd(8'h74, 8'h80);
        wr(8'hc0, 8'h00);
    endtask

    task t_fifo;
        @(posedge ref_clk) fifo_push <= 1'b1;
        repeat (3) @(posedge ref_clk);
        fifo_push <= 1'b0;
        rd(8'h78, 8'h03);
        @(posedge ref_clk) fifo_pop <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fifo_pop <= 1'b0;
        rd(8'h7c, 8'h20);
        rd(8'h7c, 8'h20);
        wr(8'h7c, 8'hff);
        rd(8'h7c, 8'h20);
        @(posedge ref_clk) fifo_clear <= 1'b1;
        @(posedge ref_clk) {fifo_clear, fifo_push} <= 2'b01;
        repeat (513) @(posedge ref_clk);
        {fifo_push, rx_active} <= 2'b01;
        rd(8'h78, 8'h00);
        rd(8'h7c, 8'h90);
        repeat (2) @(posedge ref_clk);
        check("water level", {31'h0, fifo_water_level}, 32'h1);
        {rx_active, tx_active, fifo_clear} <= 3'b011;
        @(posedge ref_clk) fifo_clear <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("water level", {31'h0, fifo_water_level}, 32'h1);
        tx_active <= 1'b0;
        {rx_end, rx_last_bits, rx_parity_missing} <= 5'b11011;
        @(posedge ref_clk) rx_end <= 1'b0;
        rd(8'h7c, 8'h0a);
        check("water level", {31'h0, fifo_water_level}, 32'h0);
        {rx_end, rx_last_bits, rx_parity_missing} <= 5'b10001;
        @(posedge ref_clk) rx_end <= 1'b0;
        check("hard error", {31'h0, hard_framing_error_flag}, 32'h0);
        rd(8'h7c, 8'h01);
    endtask

    task t_coll;
        @(posedge ref_clk) rx_start <= 1'b1;
        @(posedge ref_clk) rx_start <= 1'b0;
        col(1'b0, 4'h3, 3'h2, 1'b0);
        rd(8'h80, 8'h00);
        col(1'b1, 4'h9, 3'h5, 1'b0);
        col(1'b1, 4'h2, 3'h1, 1'b1);
        check("hard error", {31'h0, hard_framing_error_flag}, 32'h0);
        rd(8'h80, 8'h9a);
        @(posedge ref_clk) rx_start <= 1'b1;
        @(posedge ref_clk) rx_start <= 1'b0;
        col(1'b1, 4'h1, 3'h0, 1'b1);
        rd(8'h80, 8'h11);
        @(posedge ref_clk) framing_error_corrupt <= 1'b1;
        @(posedge ref_clk) framing_error_corrupt <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("hard error", {31'h0, hard_framing_error_flag}, 32'h1);
        @(posedge ref_clk) rx_start <= 1'b1;
        @(posedge ref_clk) rx_start <= 1'b0;
        @(posedge ref_clk);
        check("hard error", {31'h0, hard_framing_error_flag}, 32'h0);
    endtask

    initial
    begin
        rst = 1'b1;
        {field_wait_timer_evt, ca_done, ca_collision, auto_anticoll_reply_sent} = 4'h0;
        {auto_sensf_reply_sent, fifo_push, fifo_pop, fifo_clear, rx_active, tx_active} = 6'h0;
        {rx_start, rx_end, rx_parity_missing, framing_error_corrupt, collision_evt} = 5'h0;
        {anticoll_cmd, collision_parity_in, rx_last_bits, collision_bit_in} = 8'h0;
        {field_on, passive_target_mode, rx_rate, collision_byte_in} = 8'hd0;
        time_slot_number_unused = 8'h05;
        target_state = NTFCS_PTA_IDLE;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_flags();
        t_fifo();
        t_coll();
        finish_test();
    end
endmodule // test_nfc_target_fifo_collision_status
